// ==== rtl/htd_deglitch.sv ====
`timescale 1ns/10ps
`default_nettype none
module htd_deglitch (
	input wire logic clk_i, // System clock
	input wire logic sys_rst_i, // Async reset, high
	htd_dg_if.dg port // Comparator in, fault out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;
	logic fault_r;
	logic [htd_pkg::DG_CNT_W-1:0] cnt_r;

	// ----------------------------------------------------------------
	// Pin synchroniser and agreement filter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= port.trip;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	// ----------------------------------------------------------------
	// Continuous-trip timer
	// ----------------------------------------------------------------
	// A drop that passes the agreement filter, or a drop of arm, restarts the wait, so a glitch never accumulates
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_r <= '0;
			fault_r <= 1'b0;
		end else if (!level_r || !port.arm) begin
			cnt_r <= '0;
			fault_r <= 1'b0;
		end else if (cnt_r >= port.limit - 1'b1) begin
			fault_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	assign port.fault = fault_r;
endmodule : htd_deglitch
`default_nettype wire

// ==== rtl/htd_dg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface htd_dg_if;
	logic trip;
	logic arm;
	logic [htd_pkg::DG_CNT_W-1:0] limit;
	logic fault;
	modport dg (input trip, input arm, input limit, output fault);
	modport ctl (output trip, output arm, output limit, input fault);
endinterface : htd_dg_if
`default_nettype wire

// ==== rtl/htd_pkg.sv ====
package htd_pkg;

	// ----------------------------------------------------------------
	// Clock and deglitch timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int DG_T00_US = 25;
	localparam int DG_T01_US = 50;
	localparam int DG_T10_US = 100;
	localparam int DG_T11_US = 500;
	localparam int DG_C00 = (DG_T00_US * CLK_HZ) / 1_000_000;
	localparam int DG_C01 = (DG_T01_US * CLK_HZ) / 1_000_000;
	localparam int DG_C10 = (DG_T10_US * CLK_HZ) / 1_000_000;
	localparam int DG_C11 = (DG_T11_US * CLK_HZ) / 1_000_000;
	localparam int DG_CNT_W = 13;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_CHAN_EN = 10'h02c;
	localparam logic [9:0] IDX_THRESH = 10'h02d;
	localparam logic [9:0] IDX_DEGLITCH = 10'h02e;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h040;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h041;

	// ----------------------------------------------------------------
	// Reset values and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CHAN_EN = 8'h00;
	localparam logic [7:0] RST_THRESH = 8'h00;
	localparam logic [7:0] RST_DEGLITCH = 8'h00;
	localparam logic [4:0] RST_IRQ = 5'h00;
	localparam int HOT_LSB = 4;
	localparam int COLD_LSB = 0;
	localparam int TEMP_DEGLITCH_CODE_LSB = 2;
	localparam int CELL_DG_LSB = 0;
	localparam logic [6:0] HOT_BASE_PCT = 7'h14;
	localparam logic [6:0] COLD_BASE_PCT = 7'h3c;

	// Interrupt status bit positions
	localparam int EV_HOT = 0;
	localparam int EV_COLD = 1;
	localparam int EV_OV = 2;
	localparam int EV_UV = 3;
	localparam int EV_CB = 4;

endpackage : htd_pkg

// ==== rtl/htd_top.sv ====
// Behaviour
// - Six channel enables arm temperature protection
// - Hot limit code bits 7:4, 20-35%
// - Cold limit code bits 3:0, 60-75%
// - Temperature deglitch code bits 3:2
// - Cell voltage deglitch code bits 1:0
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module htd_top #(
	parameter int NCH = 6,
	parameter int DG_LONG_CYCLES = htd_pkg::DG_C11
) (
	input wire logic clk_i, // System clock
	input wire logic sys_rst_i, // Async reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [NCH-1:0] hot_trip_i, // Over-temp comparators
	input wire logic [NCH-1:0] cold_trip_i, // Under-temp comparators
	input wire logic [NCH-1:0] ov_trip_i, // Cell over-voltage comparators
	input wire logic [NCH-1:0] uv_trip_i, // Cell under-voltage comparators
	input wire logic [NCH-1:0] cb_trip_i, // Balancing-complete comparators
	output logic [NCH-1:0] hot_fault_o, // Deglitched over-temp
	output logic [NCH-1:0] cold_fault_o, // Deglitched under-temp
	output logic [NCH-1:0] ov_fault_o, // Deglitched over-voltage
	output logic [NCH-1:0] uv_fault_o, // Deglitched under-voltage
	output logic [NCH-1:0] balancing_complete_o, // Deglitched balancing done
	output logic [6:0] hot_limit_pct_o, // Hot threshold, percent
	output logic [6:0] cold_limit_pct_o, // Cold threshold, percent
	output logic irq_o // Level interrupt
);
	logic [7:0] temp_protect_channel_enable_r;
	logic [7:0] temp_threshold_pair_r;
	logic [7:0] comparator_deglitch_select_r;
	logic [4:0] irq_status_r;
	logic [4:0] irq_mask_r;
	logic [4:0] ev_prev_r;
	logic [4:0] ev_now;
	logic [4:0] ev_rise;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;
	logic [6:0] hot_pct_r;
	logic [6:0] cold_pct_r;
	logic [9:0] idx;
	logic wr_en;
	logic [3:0] hot_limit_code;
	logic [3:0] cold_limit_code;
	logic [1:0] temp_deglitch_code;
	logic [1:0] cell_volt_deglitch_code;
	logic [htd_pkg::DG_CNT_W-1:0] temp_limit;
	logic [htd_pkg::DG_CNT_W-1:0] cell_limit;
	logic [NCH-1:0] hot_f;
	logic [NCH-1:0] cold_f;
	logic [NCH-1:0] ov_f;
	logic [NCH-1:0] uv_f;
	logic [NCH-1:0] cb_f;

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	function automatic logic [htd_pkg::DG_CNT_W-1:0] dg_cycles(input logic [1:0] code);
		unique case (code)
			2'b00: dg_cycles = htd_pkg::DG_CNT_W'(htd_pkg::DG_C00);
			2'b01: dg_cycles = htd_pkg::DG_CNT_W'(htd_pkg::DG_C01);
			2'b10: dg_cycles = htd_pkg::DG_CNT_W'(htd_pkg::DG_C10);
			2'b11: dg_cycles = htd_pkg::DG_CNT_W'(DG_LONG_CYCLES);
		endcase
	endfunction : dg_cycles

	assign hot_limit_code = temp_threshold_pair_r[htd_pkg::HOT_LSB +: 4];
	assign cold_limit_code = temp_threshold_pair_r[htd_pkg::COLD_LSB +: 4];
	assign temp_deglitch_code = comparator_deglitch_select_r[htd_pkg::TEMP_DEGLITCH_CODE_LSB +: 2];
	assign cell_volt_deglitch_code = comparator_deglitch_select_r[htd_pkg::CELL_DG_LSB +: 2];
	assign temp_limit = dg_cycles(temp_deglitch_code);
	assign cell_limit = dg_cycles(cell_volt_deglitch_code);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hot_pct_r <= htd_pkg::HOT_BASE_PCT;
			cold_pct_r <= htd_pkg::COLD_BASE_PCT;
		end else begin
			hot_pct_r <= htd_pkg::HOT_BASE_PCT + {3'h0, hot_limit_code};
			cold_pct_r <= htd_pkg::COLD_BASE_PCT + {3'h0, cold_limit_code};
		end
	end

	// ----------------------------------------------------------------
	// Comparator deglitchers
	// ----------------------------------------------------------------
	htd_dg_if dg_hot[NCH] ();
	htd_dg_if dg_cold[NCH] ();
	htd_dg_if dg_ov[NCH] ();
	htd_dg_if dg_uv[NCH] ();
	htd_dg_if dg_cb[NCH] ();

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		assign dg_hot[i].trip = hot_trip_i[i];
		assign dg_hot[i].arm = temp_protect_channel_enable_r[i];
		assign dg_hot[i].limit = temp_limit;
		assign hot_f[i] = dg_hot[i].fault;
		assign dg_cold[i].trip = cold_trip_i[i];
		assign dg_cold[i].arm = temp_protect_channel_enable_r[i];
		assign dg_cold[i].limit = temp_limit;
		assign cold_f[i] = dg_cold[i].fault;
		// Cell enables live elsewhere; these stay armed
		assign dg_ov[i].trip = ov_trip_i[i];
		assign dg_ov[i].arm = 1'b1;
		assign dg_ov[i].limit = cell_limit;
		assign ov_f[i] = dg_ov[i].fault;
		assign dg_uv[i].trip = uv_trip_i[i];
		assign dg_uv[i].arm = 1'b1;
		assign dg_uv[i].limit = cell_limit;
		assign uv_f[i] = dg_uv[i].fault;
		assign dg_cb[i].trip = cb_trip_i[i];
		assign dg_cb[i].arm = 1'b1;
		assign dg_cb[i].limit = cell_limit;
		assign cb_f[i] = dg_cb[i].fault;

		htd_deglitch u_hot (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(dg_hot[i]));
		htd_deglitch u_cold (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(dg_cold[i]));
		htd_deglitch u_ov (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(dg_ov[i]));
		htd_deglitch u_uv (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(dg_uv[i]));
		htd_deglitch u_cb (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port(dg_cb[i]));
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// No wait state: read data is latched in setup, so pready is a flop
	assign idx = paddr[11:2];
	assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;

	function automatic logic mapped(input logic [9:0] a);
		mapped = (a == htd_pkg::IDX_CHAN_EN) || (a == htd_pkg::IDX_THRESH) ||
			(a == htd_pkg::IDX_DEGLITCH) || (a == htd_pkg::IDX_IRQ_STATUS) ||
			(a == htd_pkg::IDX_IRQ_MASK);
	endfunction : mapped

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= psel && !penable;
			pslverr_r <= psel && !penable && !mapped(idx);
			if (psel && !penable && !pwrite) begin
				unique case (idx)
					htd_pkg::IDX_CHAN_EN: prdata_r <= {24'h000000, temp_protect_channel_enable_r};
					htd_pkg::IDX_THRESH: prdata_r <= {24'h000000, temp_threshold_pair_r};
					htd_pkg::IDX_DEGLITCH: prdata_r <= {24'h000000, comparator_deglitch_select_r};
					htd_pkg::IDX_IRQ_STATUS: prdata_r <= {27'h0000000, irq_status_r};
					htd_pkg::IDX_IRQ_MASK: prdata_r <= {27'h0000000, irq_mask_r};
					default: prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Spare bits are kept as plain storage
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			temp_protect_channel_enable_r <= htd_pkg::RST_CHAN_EN;
			temp_threshold_pair_r <= htd_pkg::RST_THRESH;
			comparator_deglitch_select_r <= htd_pkg::RST_DEGLITCH;
			irq_mask_r <= htd_pkg::RST_IRQ;
		end else if (wr_en) begin
			unique case (idx)
				htd_pkg::IDX_CHAN_EN: temp_protect_channel_enable_r <= pwdata[7:0];
				htd_pkg::IDX_THRESH: temp_threshold_pair_r <= pwdata[7:0];
				htd_pkg::IDX_DEGLITCH: comparator_deglitch_select_r <= pwdata[7:0];
				htd_pkg::IDX_IRQ_MASK: irq_mask_r <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	assign ev_now[htd_pkg::EV_HOT] = |hot_f;
	assign ev_now[htd_pkg::EV_COLD] = |cold_f;
	assign ev_now[htd_pkg::EV_OV] = |ov_f;
	assign ev_now[htd_pkg::EV_UV] = |uv_f;
	assign ev_now[htd_pkg::EV_CB] = |cb_f;
	assign ev_rise = ev_now & ~ev_prev_r;

	// A new event in the clearing cycle wins over the clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ev_prev_r <= 5'h00;
			irq_status_r <= htd_pkg::RST_IRQ;
			irq_r <= 1'b0;
		end else begin
			ev_prev_r <= ev_now;
			if (wr_en && idx == htd_pkg::IDX_IRQ_STATUS) begin
				irq_status_r <= (irq_status_r & ~pwdata[4:0]) | ev_rise;
			end else begin
				irq_status_r <= irq_status_r | ev_rise;
			end
			irq_r <= |(irq_status_r & irq_mask_r);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq_o = irq_r;
	assign hot_limit_pct_o = hot_pct_r;
	assign cold_limit_pct_o = cold_pct_r;
	assign hot_fault_o = hot_f;
	assign cold_fault_o = cold_f;
	assign ov_fault_o = ov_f;
	assign uv_fault_o = uv_f;
	assign balancing_complete_o = cb_f;
endmodule : htd_top
`default_nettype wire

// ==== test/htd_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module htd_asserts #(
	parameter int NCH = 6,
	parameter int DG_LONG_CYCLES = 5000
) (
	input wire logic clk_i, // Clock
	input wire logic sys_rst_i, // Reset
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [NCH-1:0] hot_trip_i, // Hot raw
	input wire logic [NCH-1:0] cold_trip_i, // Cold raw
	input wire logic [NCH-1:0] ov_trip_i, // OV raw
	input wire logic [NCH-1:0] uv_trip_i, // UV raw
	input wire logic [NCH-1:0] cb_trip_i, // Balance raw
	input wire logic [NCH-1:0] hot_fault_o, // Hot fault
	input wire logic [NCH-1:0] cold_fault_o, // Cold fault
	input wire logic [NCH-1:0] ov_fault_o, // OV fault
	input wire logic [NCH-1:0] uv_fault_o, // UV fault
	input wire logic [NCH-1:0] balancing_complete_o, // Balance done
	input wire logic [6:0] hot_limit_pct_o, // Hot percent
	input wire logic [6:0] cold_limit_pct_o, // Cold percent
	input wire logic irq_o // Interrupt
);
	// Shortest deglitch, less slack for the input synchroniser
	localparam int MIN_RUN = (DG_LONG_CYCLES < 250 ? DG_LONG_CYCLES : 250) - 1;
	logic [12:0] run_r;
	logic wr_acc;
	assign wr_acc = psel && penable && pwrite;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) run_r <= 13'h0;
		else if (!hot_trip_i[0]) run_r <= 13'h0;
		else if (run_r != 13'h1fff) run_r <= run_r + 13'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	setup_gets_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
	ready_one_cycle_a: assert property (pready |=> !pready) else $error("ready too long");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
	read_upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	unmapped_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad rd");
	hot_pct_range_a: assert property (hot_limit_pct_o >= 7'h14 && hot_limit_pct_o <= 7'h23) else $error("hot pct");
	cold_pct_range_a: assert property (cold_limit_pct_o >= 7'h3c && cold_limit_pct_o <= 7'h4b) else $error("cold");
	pct_after_write_a: assert property ($changed(hot_limit_pct_o) |-> $past(wr_acc) || $past(wr_acc, 2))
		else $error("pct moved");
	hot_run_needed_a: assert property ($rose(hot_fault_o[0]) |-> run_r >= MIN_RUN) else $error("early fault");
	ov_release_a: assert property ((!ov_trip_i[0])[*6] |=> !ov_fault_o[0]) else $error("ov stuck");
	cover property ($rose(hot_fault_o[0]));
	cover property (pslverr);
	cover property ($rose(irq_o));
endmodule : htd_asserts
bind htd_top htd_asserts #(.NCH(NCH), .DG_LONG_CYCLES(DG_LONG_CYCLES)) htd_asserts_inst (.clk_i, .sys_rst_i,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hot_trip_i, .cold_trip_i, .ov_trip_i,
	.uv_trip_i, .cb_trip_i, .hot_fault_o, .cold_fault_o, .ov_fault_o, .uv_fault_o, .balancing_complete_o,
	.hot_limit_pct_o, .cold_limit_pct_o, .irq_o);
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int LONG = 40;
	localparam logic [9:0] IC = htd_pkg::IDX_CHAN_EN;
	localparam logic [9:0] IS = htd_pkg::IDX_IRQ_STATUS;
	logic clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, irq_o, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d;
	logic [5:0] hot_trip_i, cold_trip_i, ov_trip_i, uv_trip_i, cb_trip_i;
	logic [5:0] hot_fault_o, cold_fault_o, ov_fault_o, uv_fault_o, balancing_complete_o;
	logic [6:0] hot_limit_pct_o, cold_limit_pct_o;
	logic [7:0] mdl [3];
	logic [4:0] mstat;
	int error_cnt, checked, seed, nh, no, n, j;
	htd_top #(.NCH(6), .DG_LONG_CYCLES(LONG)) htd_top_inst (.clk_i, .sys_rst_i, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .hot_trip_i, .cold_trip_i, .ov_trip_i, .uv_trip_i,
		.cb_trip_i, .hot_fault_o, .cold_fault_o, .ov_fault_o, .uv_fault_o, .balancing_complete_o,
		.hot_limit_pct_o, .cold_limit_pct_o, .irq_o);
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : stop_test
	// Holds the request until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 9);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 9) begin
			chk(1'b0, 1'b1);
			stop_test();
		end
	endtask : apb
	task automatic rdchk(input logic [9:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task automatic meas(input int lim);
		nh = 0;
		no = 0;
		for (int k = 1; k < lim; k++) begin
			@(posedge clk_i);
			if (nh == 0 && hot_fault_o[0] === 1'b1) nh = k;
			if (no == 0 && ov_fault_o[0] === 1'b1) no = k;
		end
	endtask : meas
	initial begin
		seed = 32'h70570d80;
		error_cnt = 0;
		checked = 0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		{hot_trip_i, cold_trip_i, ov_trip_i, uv_trip_i, cb_trip_i} = 30'h0;
		mdl = '{default: 8'h00};
		mstat = 5'h00;
		sys_rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 3; i++) rdchk(IC + 10'(i), 32'h0);
		chk(hot_limit_pct_o, 32'h14);
		chk(cold_limit_pct_o, 32'h3c);
		$display("reset test done");
		repeat (12) begin
			j = {$random(seed)} % 3;
			d = $random(seed);
			apb(1'b1, IC + 10'(j), d);
			mdl[j] = d[7:0];
			rdchk(IC + 10'(j), {24'h0, mdl[j]});
		end
		apb(1'b1, 10'h3ff, 32'hffffffff);
		chk(er, 1'b1);
		$display("register test done");
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, htd_pkg::IDX_THRESH, {24'h0, 4'(c), 4'(15 - c)});
			repeat (2) @(posedge clk_i);
			chk(hot_limit_pct_o, 20 + c);
			chk(cold_limit_pct_o, 75 - c);
		end
		$display("threshold test done");
		apb(1'b1, IC, 32'h3f);
		for (int c = 0; c < 4; c++) begin
			n = c == 3 ? LONG : 250 << c;
			apb(1'b1, htd_pkg::IDX_DEGLITCH, {28'h0, 2'(c), 2'(c)});
			hot_trip_i[0] <= 1'b1;
			ov_trip_i[0] <= 1'b1;
			meas(n + 10);
			chk(nh >= n + 3 && nh <= n + 6, 1'b1);
			chk(no >= n + 3 && no <= n + 6, 1'b1);
			hot_trip_i[0] <= 1'b0;
			ov_trip_i[0] <= 1'b0;
			repeat (8) @(posedge clk_i);
			chk({hot_fault_o[0], ov_fault_o[0]}, 2'b00);
		end
		mstat = 5'h05;
		$display("deglitch test done");
		apb(1'b1, htd_pkg::IDX_DEGLITCH, 32'h0);
		apb(1'b1, IC, 32'h02);
		cold_trip_i <= 6'h03;
		hot_trip_i <= 6'h02;
		repeat (120) @(posedge clk_i);
		hot_trip_i <= 6'h00;
		repeat (150) @(posedge clk_i);
		chk(cold_fault_o, 6'h02);
		chk(hot_fault_o, 6'h00);
		cold_trip_i <= 6'h00;
		mstat = mstat | 5'h02;
		$display("arming test done");
		rdchk(IS, {27'h0, mstat});
		chk(irq_o, 1'b0);
		apb(1'b1, htd_pkg::IDX_IRQ_MASK, 32'h01);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		apb(1'b1, IS, 32'h01);
		mstat = mstat & 5'h1e;
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		rdchk(IS, {27'h0, mstat});
		$display("interrupt test done");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
